// ==== rfs_pkg.sv ====
// Shared types and constants for the receiver FIFO read-clock selection block
package rfs_pkg;
  localparam int unsigned RFS_DATA_W = 16;
  localparam int unsigned RFS_STAT_W = 2;
  localparam int unsigned RFS_DEPTH = 8;
  // Read side starts once the FIFO holds this many entries
  localparam int unsigned RFS_PRIME_LEVEL = 4;
  localparam logic RFS_FLAG_RST = 1'b0;
  localparam logic RFS_HALF_RST = 1'b0;

  // Channel configuration, one-hot
  typedef enum logic [3:0] {
    RFS_MODE_NB_RM = 4'b0001,
    RFS_MODE_NB_NORM = 4'b0010,
    RFS_MODE_BOND_X4 = 4'b0100,
    RFS_MODE_BOND_X8 = 4'b1000
  } rfs_mode_t;

  // One receiver word as it leaves the PCS
  typedef struct packed {
    logic [RFS_STAT_W-1:0] status;
    logic [RFS_DATA_W-1:0] data;
  } rfs_rx_word_t;

  // Word as stored: two halves when the byte deserializer pairs them
  typedef struct packed {
    rfs_rx_word_t hi;
    rfs_rx_word_t lo;
  } rfs_fifo_word_t;

  // Rising-edge events of each candidate clock, one system cycle wide
  typedef struct packed {
    logic tx_par;
    logic rx_rec;
    logic bond_core;
    logic master_core;
    logic user_rd;
  } rfs_clk_ticks_t;

  // Channel configuration
  typedef struct packed {
    rfs_mode_t mode;
    logic byte_deser_en;
    logic user_rd_clk_en;
  } rfs_cfg_t;

  // Sticky error flags of the FIFO
  typedef struct packed {
    logic overflow;
    logic underrun;
  } rfs_err_t;
endpackage

// ==== rfs_mem.sv ====
// Small dual-port storage for the phase compensation FIFO, registered read data
module rfs_mem #(
  parameter int unsigned WIDTH = 36,
  parameter int unsigned DEPTH = 8
) (
  // Clock
  input wire logic clk_sys_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // Read port
  input wire logic rd_en_i,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // No reset on the array, so it maps onto plain RAM
  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en_i)
    begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rd_en_i)
    begin
      rd_data_o <= mem_q[rd_addr_i];
    end
  end
endmodule // rfs_mem

// ==== rfs_rx_fifo_rdclk.sv ====
// Receiver phase compensation FIFO with write- and read-clock source selection
// Notes on behaviour
// RQ1: Enabled user read input clocks FIFO read.
// RQ2: User read clock has zero offset.
// RQ3: Any frequency mismatch overflows or underruns.
// RQ4: Rate matched non-bonded writes on transmit clock.
// RQ5: Unmatched non-bonded writes on recovered clock.
// RQ6: Four-lane bonded writes on block core clock.
// RQ7: Eight-lane bonded writes on master core clock.
// RQ8: Fabric latches data with common clock.
// RQ9: Only listed drivers may feed read input.
// RQ10: No gated or fabric-made read clocks.
// RQ11: Otherwise read clock follows channel configuration.
// RQ12: One word out per read-clock cycle.
module rfs_rx_fifo_rdclk
  import rfs_pkg::*;
#(
  parameter int unsigned DEPTH = rfs_pkg::RFS_DEPTH,
  parameter int unsigned PRIME_LEVEL = rfs_pkg::RFS_PRIME_LEVEL
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Configuration and clock events
  input rfs_pkg::rfs_cfg_t cfg_i,
  input rfs_pkg::rfs_clk_ticks_t ticks_i,
  // Receiver PCS side
  input rfs_pkg::rfs_rx_word_t rx_word_i,
  // Fabric side
  output rfs_pkg::rfs_fifo_word_t fab_word_o,
  output logic fab_valid_o,
  output logic fab_rd_tick_o,
  // Error flags
  input wire logic err_clr_i,
  output rfs_pkg::rfs_err_t err_o
);
  import rfs_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam int unsigned FW = $bits(rfs_fifo_word_t);

  logic src_tick;
  logic wr_tick;
  logic rd_tick;
  logic half_q;
  logic half_d;
  rfs_rx_word_t lo_q;
  logic primed_q;
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;
  logic rd_pend_q;
  rfs_err_t err_q;
  rfs_fifo_word_t wr_word;
  rfs_fifo_word_t mem_rd;

  // Write-clock source per channel configuration
  always_comb
  begin
    unique case (cfg_i.mode)
      // RQ4: transmit parallel clock
      RFS_MODE_NB_RM: src_tick = ticks_i.tx_par;
      // RQ5: recovered receive clock
      RFS_MODE_NB_NORM: src_tick = ticks_i.rx_rec;
      // RQ6: block core clock
      RFS_MODE_BOND_X4: src_tick = ticks_i.bond_core;
      // RQ7: master core clock
      RFS_MODE_BOND_X8: src_tick = ticks_i.master_core;
      default: src_tick = 1'b0;
    endcase
  end

  // Byte deserializer halves the write rate: every second source edge
  assign half_d = cfg_i.byte_deser_en ? (src_tick ? ~half_q : half_q) : RFS_HALF_RST;
  // All four modes: divide by two when paired
  assign wr_tick = src_tick && (!cfg_i.byte_deser_en || half_q);

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      half_q <= RFS_HALF_RST;
      lo_q <= '0;
    end
    else
    begin
      half_q <= half_d;
      if (src_tick && cfg_i.byte_deser_en && !half_q)
      begin
        lo_q <= rx_word_i;
      end
    end
  end

  always_comb
  begin
    wr_word = '0;
    if (cfg_i.byte_deser_en)
    begin
      wr_word.lo = lo_q;
      wr_word.hi = rx_word_i;
    end
    else
    begin
      wr_word.lo = rx_word_i;
    end
  end

  // RQ1: user read input replaces auto choice
  // RQ11: auto read clock equals write clock
  // A user clock that slips shows up only in the sticky error flags
  assign rd_tick = cfg_i.user_rd_clk_en ? ticks_i.user_rd : wr_tick;
  assign fab_rd_tick_o = rd_tick;

  // Level counter holds DEPTH+1 values, so full and empty never alias
  assign full = (count_q == CW'(DEPTH));
  assign empty = (count_q == '0);
  assign do_wr = wr_tick && !full;
  assign do_rd = rd_tick && primed_q && !empty;

  // Pointers and fill level
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + CW'(do_wr) - CW'(do_rd);
    end
  end

  // Reading waits for a half-full FIFO, giving phase margin both ways
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      primed_q <= RFS_FLAG_RST;
    end
    else if (count_q >= CW'(PRIME_LEVEL))
    begin
      primed_q <= 1'b1;
    end
  end

  // RQ3: sticky overflow and underrun
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      err_q <= '{overflow: RFS_FLAG_RST, underrun: RFS_FLAG_RST};
    end
    else
    begin
      // Set wins over a clear in the same cycle
      err_q.overflow <= (wr_tick && full) || (err_q.overflow && !err_clr_i);
      err_q.underrun <= (rd_tick && primed_q && empty) || (err_q.underrun && !err_clr_i);
    end
  end
  assign err_o = err_q;

  rfs_mem #(
    .WIDTH(FW),
    .DEPTH(DEPTH)
  ) u_mem (
    .clk_sys_i(clk_sys_i),
    .wr_en_i(do_wr),
    .wr_addr_i(wr_ptr_q),
    .wr_data_i(wr_word),
    .rd_en_i(do_rd),
    .rd_addr_i(rd_ptr_q),
    .rd_data_o(mem_rd)
  );

  // RQ12: one word per read edge
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rd_pend_q <= 1'b0;
    end
    else
    begin
      rd_pend_q <= do_rd;
    end
  end

  // Output word held until the next read; valid marks new data
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fab_word_o <= '0;
      fab_valid_o <= 1'b0;
    end
    else
    begin
      fab_valid_o <= rd_pend_q;
      if (rd_pend_q)
      begin
        fab_word_o <= mem_rd;
      end
    end
  end
endmodule // rfs_rx_fifo_rdclk

// ==== rfs_monitor.sv ====
// Port assertions for the receiver FIFO read-clock block
module rfs_monitor
  import rfs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Watched ports
  input rfs_pkg::rfs_cfg_t cfg_i,
  input rfs_pkg::rfs_clk_ticks_t ticks_i,
  input rfs_pkg::rfs_fifo_word_t fab_word_o,
  input wire logic fab_valid_o,
  input wire logic fab_rd_tick_o,
  input wire logic err_clr_i,
  input rfs_pkg::rfs_err_t err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic auto_w;
  logic sel_src_w;
  logic half_m_q;
  logic paced_w;
  assign auto_w = !cfg_i.user_rd_clk_en;
  // Source tick that the configured mode names
  assign sel_src_w = |(cfg_i.mode & {ticks_i.master_core, ticks_i.bond_core,
    ticks_i.rx_rec, ticks_i.tx_par});
  // Byte deserializer: only every second source edge is a word edge
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      half_m_q <= 1'b0;
    end
    else if (!cfg_i.byte_deser_en)
    begin
      half_m_q <= 1'b0;
    end
    else if (sel_src_w)
    begin
      half_m_q <= !half_m_q;
    end
  end
  assign paced_w = !cfg_i.byte_deser_en || half_m_q;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  a_user_tick: assert property (!auto_w |-> fab_rd_tick_o == ticks_i.user_rd)
    else $error("bad user tick");
  a_rm_tick: assert property (auto_w && cfg_i.mode[0] |->
    fab_rd_tick_o == (ticks_i.tx_par && paced_w))
    else $error("bad tick");
  a_nb_tick: assert property (auto_w && cfg_i.mode[1] |->
    fab_rd_tick_o == (ticks_i.rx_rec && paced_w))
    else $error("bad tick");
  a_x4_tick: assert property (auto_w && cfg_i.mode[2] |->
    fab_rd_tick_o == (ticks_i.bond_core && paced_w))
    else $error("bad tick");
  a_x8_tick: assert property (auto_w && cfg_i.mode[3] |->
    fab_rd_tick_o == (ticks_i.master_core && paced_w))
    else $error("bad tick");
  a_valid_cause: assert property (fab_valid_o |-> $past(fab_rd_tick_o, 2))
    else $error("word without tick");
  a_word_hold: assert property (!fab_valid_o |-> $stable(fab_word_o))
    else $error("word moved");
  a_ovf_sticky: assert property (err_o.overflow && !err_clr_i |=> err_o.overflow)
    else $error("flag lost");
  c_deser: cover property (fab_valid_o && cfg_i.byte_deser_en);
  c_ovf: cover property (err_o.overflow);
  c_und: cover property (err_o.underrun);
endmodule // rfs_monitor

// ==== rfs_fabric_model.sv ====
// Fabric model: shared read clock and word capture
module rfs_fabric_model
  import rfs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Read clock
  input wire logic src_tick_i,
  input wire logic slow_i,
  output logic rd_tick_o,
  // Received words
  input rfs_pkg::rfs_fifo_word_t word_i,
  input wire logic valid_i,
  output rfs_pkg::rfs_fifo_word_t word_o,
  output logic got_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph_q;
  // copy of one clean source
  // Slow halves the rate: zero-offset copy of a halved write clock, or a fault
  assign rd_tick_o = src_tick_i && (!slow_i || ph_q);
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
      ph_q <= 1'b0;
    else if (src_tick_i)
      ph_q <= !ph_q;
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
      got_o <= 1'b0;
    else
      got_o <= valid_i;
  always_ff @(posedge clk_sys_i)
    if (valid_i)
      word_o <= word_i;
endmodule // rfs_fabric_model

// ==== test_rx_fifo_read_clock_select.sv ====
// Self-checking bench for the receiver FIFO read-clock block
module test_rx_fifo_read_clock_select;
  import rfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic arst_n = 1'b0;
  logic err_clr = 1'b0;
  logic slow = 1'b0;
  logic mis = 1'b0;
  logic chk_en = 1'b0;
  logic rd_tick, got, fab_valid;
  logic [4:0] tk = '0;
  int sel = 0;
  int mismatches = 0;
  int cmp_count = 0;
  rfs_cfg_t cfg = '{RFS_MODE_NB_RM, 1'b0, 1'b0};
  rfs_rx_word_t wd = '0;
  rfs_fifo_word_t fab_word, got_word;
  rfs_err_t err;
  rfs_fifo_word_t exp_q[$];
  always #20 clk_sys_i = !clk_sys_i;
  rfs_rx_fifo_rdclk rfs_rx_fifo_rdclk_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n), .cfg_i(cfg),
    .ticks_i({tk[4:1], rd_tick}), .rx_word_i(wd), .fab_word_o(fab_word),
    .fab_valid_o(fab_valid), .fab_rd_tick_o(), .err_clr_i(err_clr), .err_o(err));
  rfs_fabric_model rfs_fabric_model_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n),
    .src_tick_i(mis ? tk[0] : tk[4-sel]), .slow_i(slow), .rd_tick_o(rd_tick),
    .word_i(fab_word), .valid_i(fab_valid), .word_o(got_word), .got_o(got));
  task automatic check(input rfs_fifo_word_t seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(negedge clk_sys_i)
    if (got && chk_en)
      check(got_word, exp_q.size() ? exp_q.pop_front() : '1);
  // Random ticks on all sources, or all held high for a bad run; only the selected one may write
  task automatic run(input int m, input logic deser, usr, bad);
    logic [17:0] lo;
    logic ph;
    int lvl;
    ph = 1'b0;
    lo = '0;
    arst_n = 1'b0;
    sel = m;
    mis = bad;
    slow = bad | (usr & deser);
    chk_en = !bad;
    cfg = '{rfs_mode_t'(4'b0001 << m), deser, usr};
    exp_q.delete();
    repeat (10) @(negedge clk_sys_i);
    arst_n = 1'b1;
    repeat (60)
    begin
      tk = bad ? 5'h1f : 5'($urandom);
      wd = 18'($urandom);
      if (tk[4-m] && !deser)
        exp_q.push_back({18'h0, wd});
      else if (tk[4-m])
      begin
        if (ph)
          exp_q.push_back({wd, lo});
        lo = wd;
        ph = !ph;
      end
      @(negedge clk_sys_i);
    end
    tk = '0;
    // Let words already read leave before the next reset
    repeat (4) @(negedge clk_sys_i);
    lvl = exp_q.size();
    if (!bad)
    begin
      check(36'(lvl >= RFS_PRIME_LEVEL && lvl <= RFS_PRIME_LEVEL + 1), 36'h1);
      check(36'(err), 36'h0);
    end
  endtask
  initial
  begin
    void'($urandom(81935));
    for (int m = 0; m < 4; m++)
      for (int d = 0; d < 2; d++)
        run(m, 1'(d), 1'b0, 1'b0);
    run(1, 1'b0, 1'b1, 1'b0);
    run(0, 1'b1, 1'b1, 1'b0);
    run(2, 1'b0, 1'b1, 1'b1);
    check(36'(err), 36'h2);
    err_clr = 1'b1;
    @(negedge clk_sys_i);
    err_clr = 1'b0;
    check(36'(err), 36'h0);
    tk = 5'h01;
    slow = 1'b0;
    repeat (20) @(negedge clk_sys_i);
    check(36'(err), 36'h1);
    wrap_up();
  end
endmodule // test_rx_fifo_read_clock_select
bind rfs_rx_fifo_rdclk rfs_monitor rfs_monitor_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
  .cfg_i(cfg_i), .ticks_i(ticks_i), .fab_word_o(fab_word_o), .fab_valid_o(fab_valid_o),
  .fab_rd_tick_o(fab_rd_tick_o), .err_clr_i(err_clr_i), .err_o(err_o));
